// ==== fel_ctrl.sv ====
// Host controller issuing erase, suspend and lock sequences to a flash.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "fel_defs.svh"

module fel_ctrl
   import fel_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output var logic HREADYOUT,
   output var logic [31:0] HRDATA,
   output var logic HRESP,
   output wire logic F_CE_N,
   output wire logic F_OE_N,
   output wire logic F_WE_N,
   output var logic F_WP_N,
   output wire logic [20:0] F_A,
   input wire logic [15:0] F_DQ_I,
   output wire logic [15:0] F_DQ_O,
   output wire logic F_DQ_OE
);

   typedef struct packed {
      fel_main_st_t st;
      fel_step_t step;
      logic [3:0] op;
      logic [20:0] addr;
      logic [15:0] wdata;
      logic [1:0] cfg;
      logic [7:0] last_stat;
      logic [7:0] err_acc;
      logic [15:0] rdata;
      logic refused;
      logic req;
      fel_cyc_req_t cyc;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] hrdata;
   } fel_ctrl_state_t;

   fel_ctrl_state_t q;
   fel_ctrl_state_t d;
   fel_pins_t pins;
   logic [15:0] cyc_rdata;
   logic cyc_done;
   logic has2;
   logic polls;
   logic [15:0] code1;
   logic [15:0] code2;
   logic [31:0] rd_val;

   // ****************************************************************
   // Flash bus cycle engine
   // ****************************************************************
   fel_cycle u_cycle (
      .clk(CLK),
      .rst(RST),
      .req(q.req),
      .req_i(q.cyc),
      .dq_i(F_DQ_I),
      .pins(pins),
      .rdata(cyc_rdata),
      .done(cyc_done)
   );

   // ****************************************************************
   // Command words of each operation
   // ****************************************************************

   // First and second flash words, and whether the sequence polls.
   always_comb
   begin
      has2 = 1'b0;
      polls = 1'b0;
      code1 = `FEL_FC_READ_ARRAY;
      code2 = `FEL_FC_CONFIRM;
      unique case (q.op)
         `FEL_OP_ERASE:
         begin
            code1 = `FEL_FC_ERASE_SETUP;
            has2 = 1'b1;
            polls = 1'b1;
         end
         `FEL_OP_PROGRAM:
         begin
            code1 = `FEL_FC_PROG_SETUP;
            code2 = q.wdata;
            has2 = 1'b1;
            polls = 1'b1;
         end
         `FEL_OP_SUSPEND:
         begin
            code1 = `FEL_FC_SUSPEND;
            polls = 1'b1;
         end
         `FEL_OP_RESUME:
         begin
            code1 = `FEL_FC_CONFIRM;
         end
         `FEL_OP_LOCK:
         begin
            code1 = `FEL_FC_PROT_SETUP;
            code2 = `FEL_FC_LOCK;
            has2 = 1'b1;
         end
         `FEL_OP_UNLOCK:
         begin
            code1 = `FEL_FC_PROT_SETUP;
            has2 = 1'b1;
         end
         `FEL_OP_LOCKDOWN:
         begin
            code1 = `FEL_FC_PROT_SETUP;
            code2 = `FEL_FC_LOCKDOWN;
            has2 = 1'b1;
         end
         `FEL_OP_CLRSTAT: code1 = `FEL_FC_CLR_STATUS;
         `FEL_OP_WRITE: code1 = q.wdata;
         default: code1 = `FEL_FC_READ_ARRAY;
      endcase
   end

   // ****************************************************************
   // Register read mux, evaluated in the address phase
   // ****************************************************************
   always_comb
   begin
      rd_val = 32'h0;
      unique case (HADDR[7:0])
         `FEL_REG_ADDR: rd_val = {11'h0, q.addr};
         `FEL_REG_WDATA: rd_val = {16'h0, q.wdata};
         `FEL_REG_STATUS:
            rd_val = {14'h0, q.refused, q.st != MS_IDLE, q.err_acc,
                      q.last_stat};
         `FEL_REG_RDATA: rd_val = {16'h0, q.rdata};
         `FEL_REG_CFG: rd_val = {30'h0, q.cfg};
         default: rd_val = 32'h0;
      endcase
   end

   // ****************************************************************
   // Bus slave and sequencer
   // ****************************************************************

   // A register write lands in its data phase; a command write in that
   // same cycle starts the sequence when the sequencer is idle.
   always_comb
   begin
      d = q;
      d.req = 1'b0;
      d.wr_pend = HSEL & HTRANS[1] & HREADY & HWRITE;
      d.wr_addr = HADDR[7:0];
      d.hrdata = (HSEL & HTRANS[1] & HREADY & ~HWRITE) ? rd_val : 32'h0;
      if (q.wr_pend)
      begin
         unique case (q.wr_addr)
            `FEL_REG_ADDR: d.addr = HWDATA[20:0];
            `FEL_REG_WDATA: d.wdata = HWDATA[15:0];
            `FEL_REG_CFG: d.cfg = HWDATA[1:0];
            default: d.cfg = q.cfg;
         endcase
      end
      unique case (q.st)
         MS_IDLE:
         begin
            if (q.wr_pend && q.wr_addr == `FEL_REG_CMD &&
                HWDATA[3:0] != `FEL_OP_NOP && HWDATA[3:0] <= `FEL_OP_PROGRAM)
            begin
               // Supply-low must be cleared before more program or erase.
               if ((HWDATA[3:0] == `FEL_OP_ERASE ||
                    HWDATA[3:0] == `FEL_OP_PROGRAM) &&
                   q.err_acc[`FEL_SB_SUPPLY_LOW])
               begin
                  d.refused = 1'b1;
               end
               else
               begin
                  d.refused = 1'b0;
                  d.op = HWDATA[3:0];
                  d.step = (HWDATA[3:0] == `FEL_OP_READ) ? K_RD : K_W1;
                  d.st = MS_ISSUE;
               end
            end
         end
         MS_ISSUE:
         begin
            // Every word and every poll goes to the operation's address,
            // which keeps status reads on the busy bank.
            d.req = 1'b1;
            d.cyc.addr = q.addr;
            d.cyc.is_read = (q.step == K_POLL) || (q.step == K_RD);
            unique case (q.step)
               K_W1: d.cyc.wdata = code1;
               K_W2: d.cyc.wdata = code2;
               default: d.cyc.wdata = `FEL_FC_READ_ARRAY;
            endcase
            d.st = MS_WAIT;
         end
         MS_WAIT:
         begin
            if (cyc_done)
            begin
               d.st = MS_ISSUE;
               unique case (q.step)
                  K_W1:
                  begin
                     if (has2)
                     begin
                        d.step = K_W2;
                     end
                     else if (polls)
                     begin
                        d.step = K_POLL;
                     end
                     else
                     begin
                        d.st = MS_IDLE;
                     end
                  end
                  K_W2:
                  begin
                     if (polls)
                     begin
                        d.step = K_POLL;
                     end
                     else
                     begin
                        d.st = MS_IDLE;
                     end
                  end
                  K_POLL:
                  begin
                     d.last_stat = cyc_rdata[7:0];
                     // Error flags pile up over several blocks.
                     d.err_acc = q.err_acc | (cyc_rdata[7:0] &
                                 `FEL_ERR_MASK);
                     if (cyc_rdata[`FEL_SB_READY])
                     begin
                        if (q.cfg[`FEL_CFG_AUTO_RA])
                        begin
                           d.step = K_RA;
                        end
                        else
                        begin
                           d.st = MS_IDLE;
                        end
                     end
                  end
                  K_RD:
                  begin
                     d.rdata = cyc_rdata;
                     d.st = MS_IDLE;
                  end
                  K_RA: d.st = MS_IDLE;
               endcase
               if (q.op == `FEL_OP_CLRSTAT && q.step == K_W1)
               begin
                  d.err_acc = 8'h0;
                  d.last_stat = 8'h0;
               end
            end
         end
      endcase
   end

   // State register; the write-protect pin starts low after reset.
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         q <= '{st: MS_IDLE, step: K_W1, op: `FEL_OP_NOP, addr: 21'h0,
                wdata: 16'h0, cfg: `FEL_CFG_RESET, last_stat: 8'h0,
                err_acc: 8'h0, rdata: 16'h0, refused: 1'b0, req: 1'b0,
                cyc: '{is_read: 1'b0, addr: 21'h0, wdata: 16'h0},
                wr_pend: 1'b0, wr_addr: 8'h0, hrdata: 32'h0};
         HREADYOUT <= 1'b1;
         HRDATA <= 32'h0;
         HRESP <= 1'b0;
         F_WP_N <= 1'b0;
      end
      else
      begin
         q <= d;
         HREADYOUT <= 1'b1; // Zero wait states, always OKAY.
         HRDATA <= d.hrdata;
         HRESP <= 1'b0;
         F_WP_N <= d.cfg[`FEL_CFG_WP_HIGH];
      end
   end

   assign F_CE_N = pins.ce_n;
   assign F_OE_N = pins.oe_n;
   assign F_WE_N = pins.we_n;
   assign F_A = pins.a;
   assign F_DQ_O = pins.dq_o;
   assign F_DQ_OE = pins.dq_oe;

endmodule : fel_ctrl

`default_nettype wire

// ==== fel_defs.svh ====
// Constants of the flash erase and lock command controller.
`ifndef FEL_DEFS_SVH
`define FEL_DEFS_SVH

// ****************************************************************
// Register offsets, byte addresses on the AHB-Lite bus
// ****************************************************************
`define FEL_REG_CMD 8'h00
`define FEL_REG_ADDR 8'h04
`define FEL_REG_WDATA 8'h08
`define FEL_REG_STATUS 8'h0c
`define FEL_REG_RDATA 8'h10
`define FEL_REG_CFG 8'h14

// ****************************************************************
// Operation codes written to the command register
// ****************************************************************
`define FEL_OP_NOP 4'h0
`define FEL_OP_READ 4'h1
`define FEL_OP_WRITE 4'h2
`define FEL_OP_ERASE 4'h3
`define FEL_OP_SUSPEND 4'h4
`define FEL_OP_RESUME 4'h5
`define FEL_OP_LOCK 4'h6
`define FEL_OP_UNLOCK 4'h7
`define FEL_OP_LOCKDOWN 4'h8
`define FEL_OP_CLRSTAT 4'h9
`define FEL_OP_READARRAY 4'ha
`define FEL_OP_PROGRAM 4'hb

// ****************************************************************
// Flash command codes
// ****************************************************************
`define FEL_FC_ERASE_SETUP 16'h0020
`define FEL_FC_CONFIRM 16'h00d0
`define FEL_FC_SUSPEND 16'h00b0
`define FEL_FC_READ_ARRAY 16'h00ff
`define FEL_FC_PROT_SETUP 16'h0060
`define FEL_FC_LOCK 16'h0001
`define FEL_FC_LOCKDOWN 16'h002f
`define FEL_FC_PROG_SETUP 16'h0040
`define FEL_FC_CLR_STATUS 16'h0050

// ****************************************************************
// Flash status bit positions
// ****************************************************************
`define FEL_SB_READY 7
`define FEL_SB_ERASE_SUSP 6
`define FEL_SB_ERASE_ERR 5
`define FEL_SB_PROG_ERR 4
`define FEL_SB_SUPPLY_LOW 3
`define FEL_SB_LOCKED 1
`define FEL_ERR_MASK 8'h3a

// ****************************************************************
// Status and configuration register fields, reset values
// ****************************************************************
`define FEL_ST_BUSY 16
`define FEL_ST_REFUSED 17
`define FEL_CFG_WP_HIGH 0
`define FEL_CFG_AUTO_RA 1
`define FEL_CFG_RESET 2'b10

// ****************************************************************
// Pin timing, in ns and in clock cycles
// ****************************************************************
`define FEL_CLK_NS 20
`define FEL_T_ACC_NS 100
`define FEL_T_WP_NS 70
`define FEL_T_REC_NS 20
`define FEL_ACC_CYC ((`FEL_T_ACC_NS + `FEL_CLK_NS - 1) / `FEL_CLK_NS)
`define FEL_WP_CYC ((`FEL_T_WP_NS + `FEL_CLK_NS - 1) / `FEL_CLK_NS)
`define FEL_REC_CYC ((`FEL_T_REC_NS + `FEL_CLK_NS - 1) / `FEL_CLK_NS)

`endif

// ==== fel_pkg.sv ====
// Types shared by the flash erase and lock command controller.
package fel_pkg;

   // ****************************************************************
   // Flash pin group and bus cycle request
   // ****************************************************************
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [20:0] a;
      logic [15:0] dq_o;
      logic dq_oe;
   } fel_pins_t;

   typedef struct packed {
      logic is_read;
      logic [20:0] addr;
      logic [15:0] wdata;
   } fel_cyc_req_t;

   // ****************************************************************
   // State machines
   // ****************************************************************
   typedef enum logic [3:0] {
      CY_IDLE = 4'b0001,
      CY_ACT = 4'b0010,
      CY_HLD = 4'b0100,
      CY_REC = 4'b1000
   } fel_cyc_st_t;

   typedef enum logic [2:0] {
      MS_IDLE = 3'b001,
      MS_ISSUE = 3'b010,
      MS_WAIT = 3'b100
   } fel_main_st_t;

   typedef enum logic [4:0] {
      K_W1 = 5'b00001,
      K_W2 = 5'b00010,
      K_POLL = 5'b00100,
      K_RA = 5'b01000,
      K_RD = 5'b10000
   } fel_step_t;

   typedef struct packed {
      fel_cyc_st_t st;
      logic [3:0] cnt;
      logic is_read;
      fel_pins_t pins;
      logic [15:0] rdata;
      logic done;
   } fel_cyc_state_t;

endpackage : fel_pkg

// ==== fel_cycle.sv ====
// One asynchronous flash bus cycle, read or write, with strobe timing.
`timescale 1ns/100ps
`default_nettype none
`include "fel_defs.svh"

module fel_cycle
   import fel_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic req,
   input wire fel_cyc_req_t req_i,
   input wire logic [15:0] dq_i,
   output var fel_pins_t pins,
   output logic [15:0] rdata,
   output logic done
);

   localparam logic [3:0] ACC_N = 4'(`FEL_ACC_CYC - 1);
   localparam logic [3:0] WP_N = 4'(`FEL_WP_CYC - 1);
   localparam logic [3:0] REC_N = 4'(`FEL_REC_CYC - 1);

   fel_cyc_state_t q;
   fel_cyc_state_t d;

   // ****************************************************************
   // Cycle sequencing
   // ****************************************************************

   // Every cycle ends with both strobes and chip enable high, so each
   // status poll is a fresh falling edge of output enable.
   always_comb
   begin
      d = q;
      d.done = 1'b0;
      unique case (q.st)
         CY_IDLE:
         begin
            if (req)
            begin
               d.st = CY_ACT;
               d.is_read = req_i.is_read;
               d.pins.a = req_i.addr;
               d.pins.ce_n = 1'b0;
               d.pins.oe_n = ~req_i.is_read;
               d.pins.we_n = req_i.is_read;
               d.pins.dq_o = req_i.wdata;
               d.pins.dq_oe = ~req_i.is_read;
               d.cnt = req_i.is_read ? ACC_N : WP_N;
            end
         end
         CY_ACT:
         begin
            if (q.cnt == 4'h0)
            begin
               d.st = CY_HLD;
               d.pins.oe_n = 1'b1;
               d.pins.we_n = 1'b1;
               if (q.is_read)
               begin
                  d.rdata = dq_i; // Sampled after the full access time.
               end
            end
            else
            begin
               d.cnt = q.cnt - 4'h1;
            end
         end
         CY_HLD:
         begin
            // Data stays driven one cycle past the write strobe edge.
            d.st = CY_REC;
            d.pins.ce_n = 1'b1;
            d.pins.dq_oe = 1'b0;
            d.cnt = REC_N;
         end
         CY_REC:
         begin
            if (q.cnt == 4'h0)
            begin
               d.st = CY_IDLE;
               d.done = 1'b1;
            end
            else
            begin
               d.cnt = q.cnt - 4'h1;
            end
         end
      endcase
   end

   // State register; pins idle high and undriven under reset.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         q <= '{st: CY_IDLE, cnt: 4'h0, is_read: 1'b0,
                pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, a: 21'h0,
                        dq_o: 16'h0, dq_oe: 1'b0},
                rdata: 16'h0, done: 1'b0};
      end
      else
      begin
         q <= d;
      end
   end

   assign pins = q.pins;
   assign rdata = q.rdata;
   assign done = q.done;

endmodule : fel_cycle

`default_nettype wire

// ==== fel_ctrl_sva.sv ====
// Port checker of the flash erase and lock controller.
`timescale 1ns/100ps
`default_nettype none
module fel_ctrl_sva
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic HSEL,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic HREADY,
   input wire logic HREADYOUT,
   input wire logic [31:0] HRDATA,
   input wire logic HRESP,
   input wire logic F_CE_N,
   input wire logic F_OE_N,
   input wire logic F_WE_N,
   input wire logic [20:0] F_A,
   input wire logic F_DQ_OE
);
   // One clock domain, so clocking and reset are stated once.
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   // The slave never waits and never errs.
   bus_okay_a: assert property
      (HREADYOUT && !HRESP)
      else $error("bus stall or error");
   read_idle_a: assert property
      (!$past(HSEL && HTRANS[1] && HREADY && !HWRITE) |-> HRDATA == 32'h0)
      else $error("read data outside a data phase");
   // Pulse shapes keep the write pulse and access times of the flash.
   we_pulse_a: assert property
      ($fell(F_WE_N) |-> !F_WE_N [*4] ##1 (F_WE_N && !F_CE_N) ##1 F_CE_N)
      else $error("write pulse shape");
   oe_pulse_a: assert property
      ($fell(F_OE_N) |-> !F_OE_N [*5] ##1 (F_OE_N && !F_CE_N) ##1 F_CE_N)
      else $error("read pulse shape");
   one_strobe_a: assert property
      (F_OE_N || F_WE_N)
      else $error("both strobes low");
   we_drive_a: assert property
      (!F_WE_N |-> F_DQ_OE && !F_CE_N)
      else $error("write without driven data");
   oe_float_a: assert property
      (!F_OE_N |-> !F_DQ_OE && !F_CE_N)
      else $error("bus fight on read");
   addr_hold_a: assert property
      (!F_CE_N && !$past(F_CE_N) |-> $stable(F_A))
      else $error("address moved within a cycle");
endmodule : fel_ctrl_sva
bind fel_ctrl fel_ctrl_sva i_sva
(
   .CLK(CLK), .RST(RST), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
   .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
   .F_CE_N(F_CE_N), .F_OE_N(F_OE_N), .F_WE_N(F_WE_N), .F_A(F_A),
   .F_DQ_OE(F_DQ_OE)
);
`default_nettype wire

// ==== fel_flash_model.sv ====
// Behavioural dual-bank flash with status, suspend and block locks.
`timescale 1ns/100ps
`default_nettype none
module fel_flash_model
(
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic wp_n,
   input wire logic [20:0] a,
   input wire logic [15:0] dq_w,
   input wire logic fail,
   input wire logic low_supply,
   output logic [15:0] dq_r
);
   logic [63:0] lk = '1;
   logic [63:0] ld = '0;
   logic [1:0] smode = 2'b00;
   logic [7:0] sr = 8'h00;
   logic [15:0] setup = 16'h0;
   logic [15:0] last = 16'h0;
   // Identification mode blocks program and erase on both banks.
   logic ident = 1'b0;
   int busy = 0;
   int ebusy = 0;
   wire logic [5:0] b = a[20:15];
   wire logic prot = lk[b] | (ld[b] & !wp_n);
   // No pull on the bus, so a released bus shows the inverse word.
   always_comb
   begin
      if (!ce_n && !oe_n && smode[a[20]])
         dq_r = {8'h00, busy == 0, sr[6:0]};
      else if (!ce_n && !oe_n)
         dq_r = a[15:0] ^ 16'h5a5a;
      else
         dq_r = ~last;
   end
   always @(dq_r)
      if (!ce_n && !oe_n)
         last = dq_r;
   // Work only advances when the host toggles the output enable.
   always @(negedge oe_n)
      if (!ce_n && busy > 0)
         busy = busy - 1;
   // Commands are taken on the rising write strobe.
   always @(posedge we_n)
   begin
      if (!ce_n)
      begin
         smode = 2'b00;
         smode[a[20]] = 1'b1;
         if (setup == 16'h0060)
         begin
            if (dq_w == 16'h0001)
               lk[b] = 1'b1;
            else if (dq_w == 16'h002f)
               {ld[b], lk[b]} = 2'b11;
            else if (dq_w == 16'h00d0)
               lk[b] = lk[b] & ld[b] & !wp_n;
            else
               sr[5:4] = 2'b11;
            setup = 16'h0;
         end
         else if (setup == 16'h0020 || setup == 16'h0040)
         begin
            if (setup == 16'h0020 && dq_w != 16'h00d0)
               sr[5:4] = 2'b11;
            else if (prot)
               sr[1] = 1'b1;
            else if (ident)
               sr[5:4] = 2'b11;
            else if (low_supply)
               sr[3] = 1'b1;
            else
               busy = (setup == 16'h0020) ? 4 : 2;
            if (setup == 16'h0020 && !prot && fail)
               sr[5] = 1'b1;
            setup = 16'h0;
         end
         else if (dq_w == 16'h00b0 && busy > 0)
         begin
            ebusy = busy;
            busy = 0;
            sr[6] = 1'b1;
         end
         else if (dq_w == 16'h00d0 && sr[6])
         begin
            busy = ebusy;
            sr[6] = 1'b0;
         end
         else if (dq_w == 16'h00ff)
            {smode, ident} = 3'b000;
         else if (dq_w == 16'h0050)
            sr[5:1] = 5'h00;
         else if (dq_w == 16'h0090)
            ident = 1'b1;
         else
            setup = dq_w;
      end
   end
endmodule : fel_flash_model
`default_nettype wire

// ==== fel_tb.sv ====
// Self-checking bench of the flash erase and lock controller.
`timescale 1ns/100ps
`default_nettype none
`include "fel_defs.svh"
module testbench;
   localparam logic [20:0] A0 = 21'h008000;
   localparam logic [20:0] A1 = 21'h010000;
   localparam logic [20:0] A2 = 21'h108000;
   localparam logic [20:0] A3 = 21'h018000;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic fail = 1'b0;
   logic low = 1'b0;
   logic idm = 1'b0;
   logic wp_e = 1'b0;
   logic [7:0] acc = 8'h00;
   logic [63:0] lk_e = '1;
   logic [63:0] ld_e = '0;
   logic [31:0] rd, x;
   wire logic [31:0] hrdata;
   wire logic hreadyout, ce_n, oe_n, we_n, wp_n, dq_oe;
   wire logic [20:0] fa;
   wire logic [15:0] dq_o, dq_r;
   wire logic [15:0] dq_i = dq_oe ? dq_o : dq_r;
   int num_errors = 0;
   int tests_run = 0;
   int k;
   fel_ctrl i_dut
   (
      .CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout),
      .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(), .F_CE_N(ce_n),
      .F_OE_N(oe_n), .F_WE_N(we_n), .F_WP_N(wp_n), .F_A(fa), .F_DQ_I(dq_i),
      .F_DQ_O(dq_o), .F_DQ_OE(dq_oe)
   );
   fel_flash_model i_flash
   (
      .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .wp_n(wp_n), .a(fa),
      .dq_w(dq_o), .fail(fail), .low_supply(low), .dq_r(dq_r)
   );
   // Free-running 50 MHz clock.
   initial forever #10 clk = ~clk;
   // Shared comparison, counting every check.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %0t: %h expected %h", $time, seen, exp);
      end
   endtask : check
   // One single AHB transfer; the address phase is held until ready.
   task automatic ahb(input logic w, input logic [7:0] ad,
      input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, ad};
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb
   // Issue a command and poll busy; the loop bound only guards a hang.
   task automatic op(input logic [3:0] c, input logic [20:0] ad);
      int n;
      n = 0;
      ahb(1'b1, `FEL_REG_ADDR, {11'h0, ad});
      ahb(1'b1, `FEL_REG_CMD, {28'h0, c});
      do
      begin
         ahb(1'b0, `FEL_REG_STATUS, 32'h0);
         n++;
      end
      while (rd[16] && n < 400);
      check(32'(rd[16]), 32'h0);
   endtask : op
   // Erase with the expected sticky error byte from the lock model.
   task automatic erase(input logic [20:0] ad, input logic f);
      fail <= f;
      op(`FEL_OP_ERASE, ad);
      if (lk_e[ad[20:15]] || (ld_e[ad[20:15]] && !wp_e))
         acc = acc | 8'h02;
      else if (idm)
         acc = acc | 8'h30;
      else if (low)
         acc = acc | 8'h08;
      else if (f)
         acc = acc | 8'h20;
      check(32'(rd[15:0]), {16'h0, acc, acc | 8'h80});
   endtask : erase
   task automatic lock(input logic [3:0] c, input logic [20:0] ad);
      logic [5:0] b;
      b = ad[20:15];
      op(c, ad);
      if (c == `FEL_OP_LOCK)
         lk_e[b] = 1'b1;
      else if (c == `FEL_OP_UNLOCK)
         lk_e[b] = lk_e[b] & ld_e[b] & !wp_e;
      else
         {ld_e[b], lk_e[b]} = 2'b11;
   endtask : lock
   task automatic rdop(input logic [20:0] ad);
      op(`FEL_OP_READ, ad);
      ahb(1'b0, `FEL_REG_RDATA, 32'h0);
   endtask : rdop
   task automatic raw(input logic [15:0] d, input logic [20:0] ad);
      ahb(1'b1, `FEL_REG_WDATA, {16'h0, d});
      op(`FEL_OP_WRITE, ad);
   endtask : raw
   task automatic clr();
      op(`FEL_OP_CLRSTAT, A0);
      acc = 8'h00;
      check(32'(rd[15:8]), 32'h0);
   endtask : clr
   task automatic setwp(input logic v);
      ahb(1'b1, `FEL_REG_CFG, {30'h0, 1'b1, v});
      wp_e = v;
   endtask : setwp
   task automatic report_and_stop();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   // Watchdog well beyond the expected run length.
   initial
   begin
      #1500000;
      num_errors++;
      report_and_stop();
   end
   // Main sequence: locks, errors, then suspend with concurrent reads.
   initial
   begin
      void'($urandom(32'he0fd));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      ahb(1'b0, `FEL_REG_CFG, 32'h0);
      check(rd, 32'h2);
      ahb(1'b1, 8'h18, 32'hffffffff);
      ahb(1'b0, 8'h18, 32'h0);
      check(rd, 32'h0);
      repeat (3)
      begin
         x = $urandom;
         ahb(1'b1, `FEL_REG_ADDR, x);
         ahb(1'b0, `FEL_REG_ADDR, 32'h0);
         check(rd, x & 32'h001fffff);
      end
      erase(A0, 1'b0);
      clr();
      lock(`FEL_OP_UNLOCK, A0);
      erase(A0, 1'b1);
      erase(A0, 1'b0);
      rdop(A0);
      check(rd, {16'h0, A0[15:0] ^ 16'h5a5a});
      clr();
      lock(`FEL_OP_LOCK, A0);
      erase(A0, 1'b0);
      clr();
      lock(`FEL_OP_LOCKDOWN, A1);
      lock(`FEL_OP_UNLOCK, A1);
      erase(A1, 1'b0);
      clr();
      setwp(1'b1);
      lock(`FEL_OP_UNLOCK, A1);
      erase(A1, 1'b0);
      low <= 1'b1;
      erase(A1, 1'b0);
      op(`FEL_OP_ERASE, A1);
      check(32'(rd[17:16]), 32'h2);
      low <= 1'b0;
      clr();
      setwp(1'b0);
      erase(A1, 1'b0);
      clr();
      lock(`FEL_OP_UNLOCK, A0);
      lock(`FEL_OP_UNLOCK, A3);
      raw(16'h0020, A0);
      raw(16'h00d0, A0);
      op(`FEL_OP_SUSPEND, A0);
      check(32'(rd[7:6]), 32'h3);
      rdop(A2);
      check(rd, {16'h0, A2[15:0] ^ 16'h5a5a});
      rdop(A3);
      check(rd, {16'h0, A3[15:0] ^ 16'h5a5a});
      ahb(1'b1, `FEL_REG_WDATA, $urandom);
      op(`FEL_OP_PROGRAM, A3);
      check(32'(rd[15:7]), 32'h1);
      op(`FEL_OP_RESUME, A0);
      rdop(A0);
      check(32'(rd[7:6]), 32'h0);
      k = 0;
      do
      begin
         rdop(A0);
         k++;
      end
      while (!rd[7] && k < 10);
      check(32'(rd[7]), 32'h1);
      op(`FEL_OP_READARRAY, A0);
      rdop(A0);
      check(rd, {16'h0, A0[15:0] ^ 16'h5a5a});
      raw(16'h0090, A3);
      idm = 1'b1;
      erase(A3, 1'b0);
      idm = 1'b0;
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
